/* File: core/drive_control_status_word.sv */
// fieldbus command word decoder and condition word builder for a drive
`timescale 1ns/1ps
`default_nettype none
`include "drive_ctl_params.svh"

module drive_control_status_word #(
    parameter int WORD_W = 16 // width of every bus word
) (
    input wire logic mclk_i, // system clock, 40 MHz
    input wire logic sys_rst_i, // synchronous reset, active high
    // words from the bus master
    input wire logic cmd_wr_i, // command word strobe
    input wire logic [WORD_W-1:0] cmd_word_i, // command word data
    input wire logic ref_wr_i, // speed reference strobe
    input wire logic [WORD_W-1:0] ref_word_i, // signed relative reference
    // configuration
    input wire logic multi_setup_en_i, // multi set-up selected
    input wire logic relay1_cw_sel_i, // relay 1 follows bus bit
    input wire logic relay4_cw_sel_i, // relay 4 follows bus bit
    input wire drive_ctl_pkg::rev_src_t rev_src_i, // reversing source
    input wire logic [WORD_W-1:0] jog_speed_i, // configured jog reference
    input wire logic [WORD_W-1:0] low_limit_i, // low speed limit
    input wire logic [WORD_W-1:0] high_limit_i, // high speed limit
    // digital inputs
    input wire logic di_reverse_i, // reverse from terminals
    input wire logic di_dc_brake_i, // DC brake from terminals
    input wire logic di_coast_i, // coast or reset-and-coast
    // drive conditions
    input wire logic ctrl_ready_i, // control section ready
    input wire logic power_ready_i, // power section supplied
    input wire logic trip_i, // drive tripped
    input wire logic error_i, // error without trip
    input wire logic trip_lock_i, // tripped and locked
    input wire logic warning_i, // warning present
    input wire logic speed_at_ref_i, // motor speed equals reference
    input wire logic local_stop_i, // local stop key active
    input wire logic local_site_i, // local reference site
    input wire logic overtemp_stop_i, // overtemperature stop, no trip
    input wire logic dc_volt_fault_i, // DC link too low or high
    input wire logic torque_over_i, // torque limit exceeded
    input wire logic thermal_over_i, // thermal timer above 100%
    input wire logic link_lost_i, // fieldbus option link lost
    input wire logic comm_fault_i, // internal communication fault
    input wire logic [WORD_W-1:0] freq_actual_i, // signed output frequency
    // decoded commands
    output drive_ctl_pkg::stop_mode_t stop_mode_o, // stop or run
    output logic run_permit_o, // start allowed by the word
    output logic trip_reset_o, // one-cycle trip reset pulse
    output logic freeze_o, // hold present output frequency
    output logic ramp2_sel_o, // second ramp pair active
    output logic [1:0] preset_sel_o, // preset reference index
    output logic [1:0] setup_sel_o, // active parameter set-up
    output logic reverse_o, // reverse rotation
    output logic relay1_o, // first output relay
    output logic relay4_o, // fourth output relay
    output logic [WORD_W-1:0] freq_target_o, // reference in use
    // words to the bus master
    output logic [WORD_W-1:0] cond_word_o, // drive condition word
    output logic [WORD_W-1:0] actual_freq_o // actual frequency word
);

    // last accepted command word, the only one acted upon
    logic [WORD_W-1:0] cmd_r;
    // bus speed reference as written
    logic [WORD_W-1:0] ref_r;
    // a strobe carrying a valid word
    logic accept;
    // decoded stop mode before registering
    drive_ctl_pkg::stop_mode_t stop_nxt;
    // condition word before the link-loss gate
    logic [WORD_W-1:0] cond_nxt;
    // magnitude of the actual frequency, for the limit test
    logic [WORD_W-1:0] freq_mag;
    logic frozen; // output frequency held
    logic rev_nxt; // reversing after source gating

    assign accept = cmd_wr_i & cmd_word_i[`CW_VALID];

    // command word store; words flagged invalid leave it untouched
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cmd_r <= `CW_RST;
        end else if (accept) begin
            cmd_r <= cmd_word_i;
        end
    end

    // reference store; kept signed, full scale is 4000 hex
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ref_r <= `REF_RST;
        end else if (ref_wr_i) begin
            ref_r <= ref_word_i;
        end
    end

    // trip reset fires on a rising edge between accepted words only,
    // so an ignored word cannot fake an edge
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            trip_reset_o <= 1'b0;
        end else begin
            trip_reset_o <= accept & cmd_word_i[`CW_RESET]
                & ~cmd_r[`CW_RESET];
        end
    end

    assign frozen = ~cmd_r[`CW_FREEZE_N];

    // stop decode: coast beats brake beats quick stop beats ramp stop;
    // a frozen output ignores the ramp-type stops
    always_comb begin
        if (~cmd_r[`CW_COAST_N] | di_coast_i) begin
            stop_nxt = drive_ctl_pkg::STOP_COAST;
        end else if (~cmd_r[`CW_DC_BRAKE_N] | di_dc_brake_i) begin
            stop_nxt = drive_ctl_pkg::STOP_DC_BRAKE;
        end else if (frozen) begin
            stop_nxt = drive_ctl_pkg::STOP_RUN;
        end else if (~cmd_r[`CW_QSTOP_N]) begin
            stop_nxt = drive_ctl_pkg::STOP_QUICK;
        end else if (~cmd_r[`CW_START]) begin
            stop_nxt = drive_ctl_pkg::STOP_RAMP;
        end else begin
            stop_nxt = drive_ctl_pkg::STOP_RUN;
        end
    end

    // reversing follows the configured source
    always_comb begin
        unique case (rev_src_i)
            drive_ctl_pkg::REV_SERIAL: rev_nxt = cmd_r[`CW_REVERSE];
            drive_ctl_pkg::REV_LOGIC_OR: begin
                rev_nxt = cmd_r[`CW_REVERSE] | di_reverse_i;
            end
            drive_ctl_pkg::REV_LOGIC_AND: begin
                rev_nxt = cmd_r[`CW_REVERSE] & di_reverse_i;
            end
            drive_ctl_pkg::REV_DIGITAL: rev_nxt = di_reverse_i;
        endcase
    end

    // registered command outputs, one cycle after the word store
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            stop_mode_o <= drive_ctl_pkg::STOP_COAST;
            run_permit_o <= 1'b0;
            freeze_o <= 1'b0;
            ramp2_sel_o <= 1'b0;
            preset_sel_o <= 2'h0;
            reverse_o <= 1'b0;
        end else begin
            stop_mode_o <= stop_nxt;
            run_permit_o <= (stop_nxt == drive_ctl_pkg::STOP_RUN)
                & cmd_r[`CW_START];
            freeze_o <= frozen;
            ramp2_sel_o <= cmd_r[`CW_RAMP2];
            // bit 01 is the high bit of the preset index
            preset_sel_o <= {cmd_r[`CW_PRESET_HI],
                cmd_r[`CW_PRESET_LO]};
            reverse_o <= rev_nxt;
        end
    end

    // relays move only when configured to follow the bus word
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            relay1_o <= 1'b0;
            relay4_o <= 1'b0;
        end else begin
            relay1_o <= cmd_r[`CW_RELAY1] & relay1_cw_sel_i;
            relay4_o <= cmd_r[`CW_RELAY4] & relay4_cw_sel_i;
        end
    end

    // set-up holds its last value while multi set-up is off,
    // so leaving multi set-up does not jump back to set-up one
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            setup_sel_o <= 2'h0;
        end else if (multi_setup_en_i) begin
            setup_sel_o <= {cmd_r[`CW_SETUP_HI],
                cmd_r[`CW_SETUP_LO]};
        end
    end

    // reference in use: jog replaces the bus reference
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            freq_target_o <= `REF_RST;
        end else begin
            freq_target_o <= cmd_r[`CW_JOG] ? jog_speed_i : ref_r;
        end
    end

    // limits compare against magnitude so reverse running counts too;
    // the most negative code saturates rather than wrapping
    always_comb begin
        if (freq_actual_i[WORD_W-1]) begin
            freq_mag = (freq_actual_i == {1'b1, {(WORD_W-1){1'b0}}})
                ? {1'b0, {(WORD_W-1){1'b1}}}
                : WORD_W'(-freq_actual_i);
        end else begin
            freq_mag = freq_actual_i;
        end
    end

    // condition word assembly from live drive conditions
    always_comb begin
        cond_nxt = `SW_RST;
        cond_nxt[`SW_CTRL_READY] = ctrl_ready_i & ~trip_i;
        // ready regardless of any active coast command
        cond_nxt[`SW_DRIVE_READY] = ctrl_ready_i & power_ready_i
            & ~trip_i;
        cond_nxt[`SW_ENABLE] = (stop_nxt != drive_ctl_pkg::STOP_COAST)
            & ~trip_i;
        cond_nxt[`SW_TRIP] = trip_i;
        cond_nxt[`SW_ERROR] = error_i;
        cond_nxt[`SW_UNUSED] = 1'b0;
        cond_nxt[`SW_TRIPLOCK] = trip_lock_i;
        cond_nxt[`SW_WARNING] = warning_i;
        cond_nxt[`SW_AT_REF] = speed_at_ref_i;
        cond_nxt[`SW_BUS_CTRL] = ~local_stop_i & ~local_site_i;
        // reaching either limit counts as outside
        cond_nxt[`SW_FREQ_OK] = (freq_mag > low_limit_i)
            & (freq_mag < high_limit_i);
        cond_nxt[`SW_RUNNING] = run_permit_o
            | (freq_actual_i != '0);
        cond_nxt[`SW_OVERTEMP] = overtemp_stop_i;
        cond_nxt[`SW_VOLTAGE] = dc_volt_fault_i;
        cond_nxt[`SW_TORQUE] = torque_over_i;
        cond_nxt[`SW_TIMER] = thermal_over_i;
    end

    // outgoing words; a lost link blanks the whole condition word
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cond_word_o <= `SW_RST;
            actual_freq_o <= `REF_RST;
        end else begin
            cond_word_o <= (link_lost_i | comm_fault_i)
                ? `SW_RST : cond_nxt;
            // same relative scaling as the reference
            actual_freq_o <= freq_actual_i;
        end
    end

    // checks on the decoded behaviour
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // invalid word leaves the store unchanged
    word_ignore_a: assert property (
        cmd_wr_i && !cmd_word_i[`CW_VALID] |=> $stable(cmd_r))
        else $error("invalid command word was stored");

    // valid word reaches the relay a cycle after the store
    relay1_follow_a: assert property (
        accept && cmd_word_i[`CW_RELAY1] && relay1_cw_sel_i
        ##1 relay1_cw_sel_i |=> relay1_o)
        else $error("relay 1 did not follow command bit");

    // rising reset bit gives exactly one pulse
    reset_edge_a: assert property (
        accept && cmd_word_i[`CW_RESET] && !cmd_r[`CW_RESET]
        |=> trip_reset_o ##1 !trip_reset_o)
        else $error("trip reset pulse missing or long");

    // steady reset bit never pulses again
    reset_steady_a: assert property (
        trip_reset_o |-> !$past(cmd_r[`CW_RESET]))
        else $error("trip reset without rising edge");

    // frozen output never ramp-stops or quick-stops
    freeze_stop_a: assert property (
        $past(frozen) |-> stop_mode_o != drive_ctl_pkg::STOP_RAMP
        && stop_mode_o != drive_ctl_pkg::STOP_QUICK)
        else $error("frozen output accepted a ramp stop");

    // coast command yields coast mode one cycle on
    coast_mode_a: assert property (
        !cmd_r[`CW_COAST_N] |=> stop_mode_o == drive_ctl_pkg::STOP_COAST)
        else $error("coast bit did not coast");

    // jog word selects the jog speed two cycles after acceptance
    jog_select_a: assert property (
        accept && cmd_word_i[`CW_JOG] ##1 $stable(jog_speed_i)
        && !cmd_wr_i |=> freq_target_o == $past(jog_speed_i))
        else $error("jog speed not applied");

    // link loss blanks the condition word
    link_blank_a: assert property (
        link_lost_i || comm_fault_i |=> cond_word_o == `SW_RST)
        else $error("condition word not blanked");

    // tripped drive never reports control ready
    trip_ready_a: assert property (
        trip_i && !link_lost_i && !comm_fault_i
        |=> !cond_word_o[`SW_CTRL_READY]
        && cond_word_o[`SW_TRIP])
        else $error("ready shown while tripped");

    // set-up holds while multi set-up is off
    setup_hold_a: assert property (
        !multi_setup_en_i |=> $stable(setup_sel_o))
        else $error("set-up changed without multi set-up");

    // unused bit always zero
    unused_bit_a: assert property (
        !cond_word_o[`SW_UNUSED])
        else $error("unused condition bit set");

    // accepted word picks the ramp pair two cycles on
    ramp_pair_a: assert property (
        accept |=> ##1 ramp2_sel_o == $past(cmd_word_i[`CW_RAMP2], 2))
        else $error("ramp pair did not follow word");

    // accepted word picks the preset index, bit 01 high
    preset_select_a: assert property (
        accept |=> ##1 preset_sel_o == $past({cmd_word_i[`CW_PRESET_HI],
        cmd_word_i[`CW_PRESET_LO]}, 2))
        else $error("preset index did not follow word");

    // set-up bits land while multi set-up is on, bit 14 high
    setup_select_a: assert property (
        accept ##1 multi_setup_en_i |=> setup_sel_o ==
        $past({cmd_word_i[`CW_SETUP_HI], cmd_word_i[`CW_SETUP_LO]}, 2))
        else $error("set-up did not follow word");

    // serial-only source reverses from the word alone
    serial_reverse_a: assert property (
        accept && rev_src_i == drive_ctl_pkg::REV_SERIAL
        ##1 rev_src_i == drive_ctl_pkg::REV_SERIAL
        |=> reverse_o == $past(cmd_word_i[`CW_REVERSE], 2))
        else $error("serial reverse bit not applied");

    // a word without start never permits running
    start_bit_a: assert property (
        accept && !cmd_word_i[`CW_START] |=> ##1 !run_permit_o)
        else $error("run permitted without start bit");

    // main scenarios
    cover_accept: cover property (accept ##1 accept);
    cover_reset: cover property (trip_reset_o);
    cover_freeze: cover property (frozen ##1 stop_mode_o ==
        drive_ctl_pkg::STOP_DC_BRAKE);
    cover_run: cover property (run_permit_o && reverse_o);

endmodule
`default_nettype wire

/* File: core/drive_ctl_params.svh */
// constants for the drive command and condition word block
`ifndef DRIVE_CTL_PARAMS_SVH
`define DRIVE_CTL_PARAMS_SVH

// command word bit positions
`define CW_PRESET_LO 0
`define CW_PRESET_HI 1
`define CW_DC_BRAKE_N 2
`define CW_COAST_N 3
`define CW_QSTOP_N 4
`define CW_FREEZE_N 5
`define CW_START 6
`define CW_RESET 7
`define CW_JOG 8
`define CW_RAMP2 9
`define CW_VALID 10
`define CW_RELAY1 11
`define CW_RELAY4 12
`define CW_SETUP_LO 13
`define CW_SETUP_HI 14
`define CW_REVERSE 15

// condition word bit positions
`define SW_CTRL_READY 0
`define SW_DRIVE_READY 1
`define SW_ENABLE 2
`define SW_TRIP 3
`define SW_ERROR 4
`define SW_UNUSED 5
`define SW_TRIPLOCK 6
`define SW_WARNING 7
`define SW_AT_REF 8
`define SW_BUS_CTRL 9
`define SW_FREQ_OK 10
`define SW_RUNNING 11
`define SW_OVERTEMP 12
`define SW_VOLTAGE 13
`define SW_TORQUE 14
`define SW_TIMER 15

// reset values: command word coasts, reference zero
`define CW_RST 16'h0000
`define REF_RST 16'h0000
`define SW_RST 16'h0000

// relative reference scale: this code means 100 percent
`define REF_FULL_SCALE 16'h4000

`endif

/* File: core/drive_ctl_pkg.sv */
// types shared by the drive command and condition word block
package drive_ctl_pkg;

    // how the motor is being stopped, or that it may run
    typedef enum logic [4:0] {
        STOP_RUN = 5'b00001,
        STOP_RAMP = 5'b00010,
        STOP_QUICK = 5'b00100,
        STOP_DC_BRAKE = 5'b01000,
        STOP_COAST = 5'b10000
    } stop_mode_t;

    // configured source for the reversing command
    typedef enum logic [1:0] {
        REV_DIGITAL = 2'h0,
        REV_SERIAL = 2'h1,
        REV_LOGIC_OR = 2'h2,
        REV_LOGIC_AND = 2'h3
    } rev_src_t;

endpackage

/* File: dv/bus_master_model.sv */
// behavioural fieldbus master that writes command and reference words
`timescale 1ns/1ps
`default_nettype none

module bus_master_model (
    input wire logic mclk_i, // system clock
    output logic cmd_wr_o, // command word strobe
    output logic [15:0] cmd_word_o, // command word data
    output logic ref_wr_o, // reference strobe
    output logic [15:0] ref_word_o // signed relative reference
);
    // idle with strobes low until the bench asks for a transfer
    initial begin
        cmd_wr_o = 1'b0;
        cmd_word_o = 16'h0000;
        ref_wr_o = 1'b0;
        ref_word_o = 16'h0000;
    end

    // one-cycle strobe; the caller toggles bit 07 to repeat a reset
    task automatic send_cmd(input logic [15:0] w);
        @(posedge mclk_i);
        #1;
        cmd_wr_o = 1'b1;
        cmd_word_o = w;
        @(posedge mclk_i);
        #1;
        cmd_wr_o = 1'b0;
        // stale data is inverted so a late sample cannot look right
        cmd_word_o = ~w;
    endtask

    // two's complement relative value, 16'h4000 means full scale
    task automatic send_ref(input logic signed [15:0] r);
        @(posedge mclk_i);
        #1;
        ref_wr_o = 1'b1;
        ref_word_o = r;
        @(posedge mclk_i);
        #1;
        ref_wr_o = 1'b0;
        ref_word_o = ~r;
    endtask
endmodule

`default_nettype wire

/* File: dv/tb_top.sv */
// self-checking bench for the drive command and condition word block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk_i = 1'b0; // 40 MHz system clock
    logic sys_rst_i = 1'b1; // held for the first 20 cycles
    logic cmd_wr, ref_wr; // strobes from the master model
    logic [15:0] cmd_word, ref_word; // words from the master model
    logic multi_en = 1'b1; // multi set-up configured
    logic r1_sel = 1'b1; // relay 1 follows its bus bit
    logic r4_sel = 1'b1; // relay 4 follows its bus bit
    drive_ctl_pkg::rev_src_t rev_src = drive_ctl_pkg::REV_SERIAL;
    logic [15:0] jog = 16'h2000; // configured jog reference
    logic [15:0] lo = 16'h0800; // low speed limit
    logic [15:0] hi = 16'h1800; // high speed limit
    logic [15:0] freq = 16'h0000; // actual frequency fed in
    logic di_rev = 1'b0; // reverse terminal
    logic di_brk = 1'b0; // dc brake terminal
    logic di_cst = 1'b0; // coast terminal
    // drive conditions: ready, power, trip ... link lost, comm fault
    logic [14:0] cin = 15'h0003;
    drive_ctl_pkg::stop_mode_t stop_mode; // decoded stop
    logic run_permit, trip_reset, freeze, ramp2, reverse, relay1, relay4;
    logic [1:0] preset, setup;
    logic [15:0] ftarget, cond, actual_freq;
    logic [15:0] lw = 16'h0000; // last accepted word, reset coasts
    logic [15:0] last_ref = 16'h0000; // last reference sent
    logic [1:0] setup_exp = 2'h0; // set-up the block should hold
    logic [15:0] words [12] = '{16'h047c, 16'h0000, 16'h0474, 16'h0478,
        16'h046c, 16'h043c, 16'h045c, 16'h044c, 16'h0454, 16'h0458,
        16'h047c, 16'h045c};
    logic [15:0] rst_words [7] = '{16'h0400, 16'h0480, 16'h0480, 16'h0000,
        16'h0480, 16'h0400, 16'h0480};
    int errors = 0;
    int compares = 0;
    int pulses = 0; // cycles with the trip reset pulse high
    int p0;

    bus_master_model bus_master_model_inst (.mclk_i(mclk_i),
        .cmd_wr_o(cmd_wr), .cmd_word_o(cmd_word),
        .ref_wr_o(ref_wr), .ref_word_o(ref_word));

    drive_control_status_word drive_control_status_word_inst (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .cmd_wr_i(cmd_wr), .cmd_word_i(cmd_word),
        .ref_wr_i(ref_wr), .ref_word_i(ref_word),
        .multi_setup_en_i(multi_en), .relay1_cw_sel_i(r1_sel),
        .relay4_cw_sel_i(r4_sel), .rev_src_i(rev_src),
        .jog_speed_i(jog), .low_limit_i(lo), .high_limit_i(hi),
        .di_reverse_i(di_rev), .di_dc_brake_i(di_brk), .di_coast_i(di_cst),
        .ctrl_ready_i(cin[0]), .power_ready_i(cin[1]), .trip_i(cin[2]),
        .error_i(cin[3]), .trip_lock_i(cin[4]), .warning_i(cin[5]),
        .speed_at_ref_i(cin[6]), .local_stop_i(cin[7]),
        .local_site_i(cin[8]), .overtemp_stop_i(cin[9]),
        .dc_volt_fault_i(cin[10]), .torque_over_i(cin[11]),
        .thermal_over_i(cin[12]), .link_lost_i(cin[13]),
        .comm_fault_i(cin[14]), .freq_actual_i(freq),
        .stop_mode_o(stop_mode), .run_permit_o(run_permit),
        .trip_reset_o(trip_reset), .freeze_o(freeze), .ramp2_sel_o(ramp2),
        .preset_sel_o(preset), .setup_sel_o(setup), .reverse_o(reverse),
        .relay1_o(relay1), .relay4_o(relay4), .freq_target_o(ftarget),
        .cond_word_o(cond), .actual_freq_o(actual_freq));

    // free-running clock, 25 ns period
    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // count every cycle the reset pulse is high, so a stuck pulse shows
    always @(posedge mclk_i) begin
        if (trip_reset === 1'b1) pulses++;
    end

    // one comparison; four-state equality so an unknown seen never matches a known value
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t: %s seen %h expected %h", $time, what,
                     seen, exp);
        end
    endtask

    // stop priority: coast, brake, freeze, quick, ramp, run
    function automatic drive_ctl_pkg::stop_mode_t
        exp_mode(input logic [15:0] w);
        if (!w[3] || di_cst) return drive_ctl_pkg::STOP_COAST;
        if (!w[2] || di_brk) return drive_ctl_pkg::STOP_DC_BRAKE;
        if (!w[5]) return drive_ctl_pkg::STOP_RUN;
        if (!w[4]) return drive_ctl_pkg::STOP_QUICK;
        if (!w[6]) return drive_ctl_pkg::STOP_RAMP;
        return drive_ctl_pkg::STOP_RUN;
    endfunction

    // reversing depends on the configured source
    function automatic logic exp_rev(input logic w15);
        case (rev_src)
            drive_ctl_pkg::REV_DIGITAL: return di_rev;
            drive_ctl_pkg::REV_SERIAL: return w15;
            drive_ctl_pkg::REV_LOGIC_OR: return w15 | di_rev;
            default: return w15 & di_rev;
        endcase
    endfunction

    // condition word built from the inputs and the accepted word
    function automatic logic [15:0] exp_cond();
        logic [15:0] mag;
        logic run;
        mag = freq[15] ? -freq : freq;
        run = (exp_mode(lw) == drive_ctl_pkg::STOP_RUN) && lw[6];
        if (cin[13] || cin[14]) return 16'h0000;
        return {cin[12:9], run || (freq != 16'h0000),
                (mag > lo) && (mag < hi), ~cin[7] & ~cin[8], cin[6],
                cin[5], cin[4], 1'b0, cin[3], cin[2],
                (exp_mode(lw) != drive_ctl_pkg::STOP_COAST) && !cin[2],
                cin[0] & cin[1] & ~cin[2], cin[0] & ~cin[2]};
    endfunction

    // send one word, let it settle, compare every decoded output but the trip reset pulse
    task automatic apply(input logic [15:0] w);
        drive_ctl_pkg::stop_mode_t m;
        bus_master_model_inst.send_cmd(w);
        repeat (3) @(posedge mclk_i);
        #1;
        if (w[10]) lw = w;
        if (w[10] && multi_en) setup_exp = w[14:13];
        m = exp_mode(lw);
        check(16'(stop_mode), 16'(m), "stop mode");
        check(16'(run_permit), 16'(m == drive_ctl_pkg::STOP_RUN && lw[6]),
              "run permit");
        check(16'(freeze), 16'(!lw[5]), "freeze");
        check(16'(ramp2), 16'(lw[9]), "ramp pair");
        check(16'(preset), 16'(lw[1:0]), "preset");
        check(16'(setup), 16'(setup_exp), "set-up");
        check(16'(reverse), 16'(exp_rev(lw[15])), "reverse");
        check(16'({relay4, relay1}), 16'({lw[12] & r4_sel, lw[11] & r1_sel}),
              "relays");
        check(ftarget, lw[8] ? jog : last_ref, "target");
        check(cond, exp_cond(), "condition");
    endtask

    // verdict and end of run, shared with the watchdog
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a hang is cut short well past the expected run length
    initial begin
        repeat (5000) @(posedge mclk_i);
        errors++;
        give_verdict();
    end

    // main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1;
        check(16'(stop_mode), 16'(drive_ctl_pkg::STOP_COAST), "reset");
        bus_master_model_inst.send_ref(16'h4000);
        last_ref = 16'h4000;
        // stop modes, an ignored word, freeze against quick stop, coast, brake and the brake terminal
        foreach (words[k]) begin
            di_cst = (k == 10);
            di_brk = (k == 11);
            apply(words[k]);
        end
        di_brk = 1'b0;
        // option bits over every source and set-up, then set-ups locked
        for (int j = 0; j < 2; j++) begin
            bus_master_model_inst.send_ref(j ? 16'hc000 : 16'h1000);
            last_ref = j ? 16'hc000 : 16'h1000;
            for (int i = 0; i < 4; i++) begin
                multi_en = (j == 0);
                rev_src = drive_ctl_pkg::rev_src_t'(i);
                di_rev = i[0];
                r1_sel = i[1];
                r4_sel = !i[1];
                apply(16'h047c | (16'(i) << 13) | 16'(3 - i) | (16'(i) << 8)
                      | (16'(i) << 11) | {i[1] ^ j[0], 15'h0});
            end
        end
        // reset pulses: rising edges only, ignored words do not count
        p0 = pulses;
        foreach (rst_words[k]) bus_master_model_inst.send_cmd(rst_words[k]);
        lw = 16'h0480;
        repeat (3) @(posedge mclk_i);
        #1;
        check(16'(pulses - p0), 16'h0002, "reset pulses");
        // each drive condition in turn, frequency stepping over limits;
        // the first two steps drop one ready input at a time
        for (int k = 0; k < 15; k++) begin
            cin = 15'h0003 ^ (15'h0001 << k);
            freq = 16'(k) * 16'h0400 - 16'h1c00;
            repeat (3) @(posedge mclk_i);
            #1;
            check(cond, exp_cond(),
                  "condition");
            check(actual_freq, freq, "actual freq");
        end
        give_verdict();
    end
endmodule

`default_nettype wire
